/* File: hw/uds_pkg.sv */
// descriptor store package: constants, carriers and the contract list
// assumes one 25 MHz core clock; eeprom loader presents field values after reset
// Contract
// - interface 0 descriptor is nine bytes, type 04h, number 00h, alt 00h, three endpoints.
// - class, subclass, protocol and string index come from eeprom, else FFh, 00h, FFh, 00h.
// - endpoint 1 is fixed: length 07h, type 05h, address 81h, bulk 02h, interval 00h.
// - at high speed both bulk endpoints report a 512 byte maximum packet.
// - endpoint 2 is fixed: address 02h, bulk 02h, interval 00h.
// - endpoint 3 is fixed at address 83h, interrupt 03h, maximum packet 10h.
// - endpoint 3 interval alone comes from eeprom, else 04h.
// - other speed configuration is length 09h, type 07h, total 0027h, one interface, value 01h.
// - other speed descriptor uses the eeprom set of the opposite speed.
// - other speed attributes come from eeprom, default A0h.
// - the remote wakeup strap sets the wakeup bit of the default attributes.
// - maximum power defaults to 01h self powered, FAh bus powered, unless eeprom gives one.
// - other speed configuration string index comes from eeprom, else 00h.
package uds_pkg;

  // ****************************************************************
  // descriptor selection
  // ****************************************************************
  typedef enum logic [2:0] {
    UDS_SEL_INTF, UDS_SEL_EP1, UDS_SEL_EP2, UDS_SEL_EP3, UDS_SEL_OSC
  } uds_sel_type;

  localparam logic [7:0]  UDS_LEN_INTF   = 8'h09;
  localparam logic [7:0]  UDS_TYPE_INTF  = 8'h04;
  localparam logic [7:0]  UDS_NUM_EPS    = 8'h03;
  localparam logic [7:0]  UDS_LEN_EP     = 8'h07;
  localparam logic [7:0]  UDS_TYPE_EP    = 8'h05;
  localparam logic [7:0]  UDS_EP1_ADDR   = 8'h81;
  localparam logic [7:0]  UDS_EP2_ADDR   = 8'h02;
  localparam logic [7:0]  UDS_EP3_ADDR   = 8'h83;
  localparam logic [7:0]  UDS_ATTR_BULK  = 8'h02;
  localparam logic [7:0]  UDS_ATTR_INTR  = 8'h03;
  localparam logic [15:0] UDS_MPS_HS     = 16'h0200;
  localparam logic [15:0] UDS_MPS_FS     = 16'h0040;
  localparam logic [15:0] UDS_MPS_EP3    = 16'h0010;
  localparam logic [7:0]  UDS_LEN_OSC    = 8'h09;
  localparam logic [7:0]  UDS_TYPE_OSC   = 8'h07;
  localparam logic [15:0] UDS_TOTAL_OSC  = 16'h0027;
  localparam logic [7:0]  UDS_ONE        = 8'h01;
  localparam logic [7:0]  UDS_ZERO       = 8'h00;

  // ****************************************************************
  // defaults used when no eeprom image is present
  // ****************************************************************
  localparam logic [7:0]  UDS_DEF_CLASS  = 8'hFF;
  localparam logic [7:0]  UDS_DEF_SUB    = 8'h00;
  localparam logic [7:0]  UDS_DEF_PROTO  = 8'hFF;
  localparam logic [7:0]  UDS_DEF_STR    = 8'h00;
  localparam logic [7:0]  UDS_DEF_EP3INT = 8'h04;
  localparam logic [7:0]  UDS_DEF_ATTR   = 8'hA0;
  localparam int          UDS_WAKE_BIT   = 5;
  localparam logic [7:0]  UDS_PWR_SELF   = 8'h01;
  localparam logic [7:0]  UDS_PWR_BUS    = 8'hFA;

  // fields written by the eeprom loader, one set per speed for the configuration bytes
  typedef struct packed {
    logic [7:0] intfClass;
    logic [7:0] intfSub;
    logic [7:0] intfProto;
    logic [7:0] intfStr;
    logic [7:0] ep3Interval;
    logic [7:0] hsCfgStr;
    logic [7:0] hsCfgAttr;
    logic [7:0] hsMaxPower;
    logic [7:0] fsCfgStr;
    logic [7:0] fsCfgAttr;
    logic [7:0] fsMaxPower;
  } uds_eeprom_type;

  typedef struct packed {
    uds_sel_type sel;
    logic [7:0]  reqLen;
  } uds_req_type;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } uds_byte_type;

endpackage

/* File: hw/uds_rom.sv */
// descriptor byte table: one registered read port over the five descriptors
// assumes field values are stable while a descriptor is being read out
`timescale 1ns/1ps
module uds_rom (
  input  wire logic                    clk,       // core clock
  input  wire logic                    rst,       // async reset, high
  input  wire uds_pkg::uds_sel_type    sel,       // descriptor select
  input  wire logic [3:0]              idx,       // byte offset
  input  wire logic                    highSpeed, // current speed is high speed
  input  wire logic                    selfPower, // self powered mode
  input  wire logic                    remote_wakeup_strap, // sampled strap
  input  wire logic                    eeValid,   // loaded image present
  input  wire uds_pkg::uds_eeprom_type ee,        // loaded fields
  output logic [7:0]                   rdata,     // registered byte
  output logic [7:0]                   dlen       // registered descriptor length
);
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] dlen;
  } uds_rom_st_type;
  uds_rom_st_type st_q, st_d;
  logic [7:0] attrDef, pwrDef, cfgStr, cfgAttr, cfgPwr, b;
  logic [15:0] mps;

  function automatic logic [7:0] pick(input logic v, input logic [7:0] e, input logic [7:0] d);
    return v ? e : d;
  endfunction

  always_comb begin
    // strap drives the wakeup bit of the default attributes
    attrDef = uds_pkg::UDS_DEF_ATTR;
    attrDef[uds_pkg::UDS_WAKE_BIT] = remote_wakeup_strap;
    pwrDef  = selfPower ? uds_pkg::UDS_PWR_SELF : uds_pkg::UDS_PWR_BUS;
    // other speed descriptor takes the opposite speed set
    cfgStr  = pick(eeValid, highSpeed ? ee.fsCfgStr : ee.hsCfgStr, uds_pkg::UDS_DEF_STR);
    cfgAttr = pick(eeValid, highSpeed ? ee.fsCfgAttr : ee.hsCfgAttr, attrDef);
    cfgPwr  = pick(eeValid, highSpeed ? ee.fsMaxPower : ee.hsMaxPower, pwrDef);
    mps     = highSpeed ? uds_pkg::UDS_MPS_HS : uds_pkg::UDS_MPS_FS;
    b = uds_pkg::UDS_ZERO;
    st_d = st_q;
    unique case (sel)
      uds_pkg::UDS_SEL_INTF: begin
        st_d.dlen = uds_pkg::UDS_LEN_INTF;
        unique case (idx)
          4'h0: b = uds_pkg::UDS_LEN_INTF;
          4'h1: b = uds_pkg::UDS_TYPE_INTF;
          4'h4: b = uds_pkg::UDS_NUM_EPS;
          4'h5: b = pick(eeValid, ee.intfClass, uds_pkg::UDS_DEF_CLASS);
          4'h6: b = pick(eeValid, ee.intfSub, uds_pkg::UDS_DEF_SUB);
          4'h7: b = pick(eeValid, ee.intfProto, uds_pkg::UDS_DEF_PROTO);
          4'h8: b = pick(eeValid, ee.intfStr, uds_pkg::UDS_DEF_STR);
          default: b = uds_pkg::UDS_ZERO;
        endcase
      end
      uds_pkg::UDS_SEL_EP1, uds_pkg::UDS_SEL_EP2, uds_pkg::UDS_SEL_EP3: begin
        st_d.dlen = uds_pkg::UDS_LEN_EP;
        unique case (idx)
          4'h0: b = uds_pkg::UDS_LEN_EP;
          4'h1: b = uds_pkg::UDS_TYPE_EP;
          4'h2: b = (sel == uds_pkg::UDS_SEL_EP1) ? uds_pkg::UDS_EP1_ADDR :
                    (sel == uds_pkg::UDS_SEL_EP2) ? uds_pkg::UDS_EP2_ADDR :
                    uds_pkg::UDS_EP3_ADDR;
          4'h3: b = (sel == uds_pkg::UDS_SEL_EP3) ? uds_pkg::UDS_ATTR_INTR
                                                  : uds_pkg::UDS_ATTR_BULK;
          4'h4: b = (sel == uds_pkg::UDS_SEL_EP3) ? uds_pkg::UDS_MPS_EP3[7:0] : mps[7:0];
          4'h5: b = (sel == uds_pkg::UDS_SEL_EP3) ? uds_pkg::UDS_MPS_EP3[15:8] : mps[15:8];
          4'h6: b = (sel == uds_pkg::UDS_SEL_EP3) ?
                    pick(eeValid, ee.ep3Interval, uds_pkg::UDS_DEF_EP3INT) : uds_pkg::UDS_ZERO;
          default: b = uds_pkg::UDS_ZERO;
        endcase
      end
      uds_pkg::UDS_SEL_OSC: begin
        st_d.dlen = uds_pkg::UDS_LEN_OSC;
        unique case (idx)
          4'h0: b = uds_pkg::UDS_LEN_OSC;
          4'h1: b = uds_pkg::UDS_TYPE_OSC;
          4'h2: b = uds_pkg::UDS_TOTAL_OSC[7:0];
          4'h3: b = uds_pkg::UDS_TOTAL_OSC[15:8];
          4'h4: b = uds_pkg::UDS_ONE;
          4'h5: b = uds_pkg::UDS_ONE;
          4'h6: b = cfgStr;
          4'h7: b = cfgAttr;
          4'h8: b = cfgPwr;
          default: b = uds_pkg::UDS_ZERO;
        endcase
      end
      default: st_d.dlen = uds_pkg::UDS_ZERO;
    endcase
    st_d.rdata = b;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign rdata = st_q.rdata;
  assign dlen  = st_q.dlen;
endmodule // uds_rom

/* File: hw/uds_store.sv */
// descriptor store top: takes a request, streams bytes one per two cycles
// assumes the control logic holds the request valid for one cycle while idle
`timescale 1ns/1ps
module uds_store (
  input  wire logic                    clk,       // core clock, 25 MHz
  input  wire logic                    rst,       // async reset, high
  input  wire logic                    reqValid,  // request strobe
  input  wire uds_pkg::uds_req_type    req,       // descriptor and requested length
  input  wire logic                    highSpeed, // current speed is high speed
  input  wire logic                    selfPower, // self powered mode
  input  wire logic                    remote_wakeup_strap, // strap level
  input  wire logic                    eeValid,   // eeprom image loaded
  input  wire uds_pkg::uds_eeprom_type ee,        // loaded field values
  output uds_pkg::uds_byte_type        dout,      // byte stream
  output logic                         busy       // transfer in progress
);
  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_SEND} uds_state_type;
  typedef struct packed {
    uds_state_type        state;
    uds_pkg::uds_sel_type sel;
    logic [7:0]           reqLen;
    logic [3:0]           idx;
    logic                 strapDone;
    logic                 strap;
    uds_pkg::uds_byte_type dout;
    logic                 busy;
  } uds_st_type;
  uds_st_type st_q, st_d;
  logic [7:0] romData, romLen, limit;

  uds_rom u_rom (
    .clk                 (clk),
    .rst                 (rst),
    .sel                 (st_q.sel),
    .idx                 (st_q.idx),
    .highSpeed           (highSpeed),
    .selfPower           (selfPower),
    .remote_wakeup_strap (st_q.strap),
    .eeValid             (eeValid),
    .ee                  (ee),
    .rdata               (romData),
    .dlen                (romLen)
  );

  always_comb begin
    st_d = st_q;
    st_d.dout.valid = 1'b0;
    st_d.dout.last  = 1'b0;
    limit = (st_q.reqLen < romLen) ? st_q.reqLen : romLen;
    // strap is caught once, the first clocked cycle after reset release
    if (!st_q.strapDone) begin
      st_d.strap     = remote_wakeup_strap;
      st_d.strapDone = 1'b1;
    end
    unique case (st_q.state)
      S_IDLE: if (reqValid) begin
        st_d.sel    = req.sel;
        st_d.reqLen = req.reqLen;
        st_d.idx    = 4'h0;
        st_d.busy   = 1'b1;
        st_d.state  = S_FETCH;
      end
      S_FETCH: st_d.state = S_SEND;
      S_SEND: begin
        if ({4'h0, st_q.idx} >= limit) begin
          st_d.state = S_IDLE;
          st_d.busy  = 1'b0;
        end else begin
          st_d.dout.valid = 1'b1;
          st_d.dout.data  = romData;
          st_d.dout.last  = ({4'h0, st_q.idx} + 8'h01) >= limit;
          st_d.idx        = st_q.idx + 4'h1;
          st_d.state      = S_FETCH;
          if (st_d.dout.last) begin
            st_d.state = S_IDLE;
            st_d.busy  = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign dout = st_q.dout;
  assign busy = st_q.busy;

  // ****************************************************************
  // checks
  // ****************************************************************
  // in the send state the table output belongs to the held offset
  logic sndIntf, sndEp1, sndEp2, sndEp3, sndOsc;
  assign sndIntf = (st_q.state == S_SEND) && (st_q.sel == uds_pkg::UDS_SEL_INTF);
  assign sndEp1  = (st_q.state == S_SEND) && (st_q.sel == uds_pkg::UDS_SEL_EP1);
  assign sndEp2  = (st_q.state == S_SEND) && (st_q.sel == uds_pkg::UDS_SEL_EP2);
  assign sndEp3  = (st_q.state == S_SEND) && (st_q.sel == uds_pkg::UDS_SEL_EP3);
  assign sndOsc  = (st_q.state == S_SEND) && (st_q.sel == uds_pkg::UDS_SEL_OSC);

  // ****************************************************************
  // interface descriptor
  // ****************************************************************
  a_intf_len: assert property (@(posedge clk) disable iff (rst)
    sndIntf |-> romLen == uds_pkg::UDS_LEN_INTF)
    else $error("interface length wrong");
  a_intf_type: assert property (@(posedge clk) disable iff (rst)
    (sndIntf && st_q.idx == 4'h1) |-> romData == uds_pkg::UDS_TYPE_INTF)
    else $error("interface type wrong");
  a_intf_num: assert property (@(posedge clk) disable iff (rst)
    (sndIntf && st_q.idx == 4'h2) |-> romData == uds_pkg::UDS_ZERO)
    else $error("interface number wrong");
  a_intf_alt: assert property (@(posedge clk) disable iff (rst)
    (sndIntf && st_q.idx == 4'h3) |-> romData == uds_pkg::UDS_ZERO)
    else $error("alternate setting wrong");
  a_intf_neps: assert property (@(posedge clk) disable iff (rst)
    (sndIntf && st_q.idx == 4'h4) |-> romData == uds_pkg::UDS_NUM_EPS)
    else $error("endpoint count wrong");
  a_class_def: assert property (@(posedge clk) disable iff (rst)
    (sndIntf && st_q.idx == 4'h5 && !eeValid) |-> romData == uds_pkg::UDS_DEF_CLASS)
    else $error("class default wrong");
  a_class_load: assert property (@(posedge clk) disable iff (rst)
    (sndIntf && st_q.idx == 4'h5 && eeValid) |-> romData == ee.intfClass)
    else $error("loaded class wrong");
  a_sub_def: assert property (@(posedge clk) disable iff (rst)
    (sndIntf && st_q.idx == 4'h6 && !eeValid) |-> romData == uds_pkg::UDS_DEF_SUB)
    else $error("subclass default wrong");
  a_proto_def: assert property (@(posedge clk) disable iff (rst)
    (sndIntf && st_q.idx == 4'h7 && !eeValid) |-> romData == uds_pkg::UDS_DEF_PROTO)
    else $error("protocol default wrong");
  a_istr_def: assert property (@(posedge clk) disable iff (rst)
    (sndIntf && st_q.idx == 4'h8 && !eeValid) |-> romData == uds_pkg::UDS_DEF_STR)
    else $error("interface string default wrong");

  // ****************************************************************
  // endpoint descriptors
  // ****************************************************************
  a_ep_len: assert property (@(posedge clk) disable iff (rst)
    (sndEp1 || sndEp2 || sndEp3) |-> romLen == uds_pkg::UDS_LEN_EP)
    else $error("endpoint length wrong");
  a_ep1_addr: assert property (@(posedge clk) disable iff (rst)
    (sndEp1 && st_q.idx == 4'h2) |-> romData == uds_pkg::UDS_EP1_ADDR)
    else $error("ep1 address wrong");
  a_ep1_attr: assert property (@(posedge clk) disable iff (rst)
    (sndEp1 && st_q.idx == 4'h3) |-> romData == uds_pkg::UDS_ATTR_BULK)
    else $error("ep1 attribute wrong");
  a_ep1_ival: assert property (@(posedge clk) disable iff (rst)
    (sndEp1 && st_q.idx == 4'h6) |-> romData == uds_pkg::UDS_ZERO)
    else $error("ep1 interval wrong");
  a_mps_hs_lo: assert property (@(posedge clk) disable iff (rst)
    ((sndEp1 || sndEp2) && st_q.idx == 4'h4 && highSpeed) |-> romData == uds_pkg::UDS_MPS_HS[7:0])
    else $error("bulk packet size low byte wrong");
  a_mps_hs_hi: assert property (@(posedge clk) disable iff (rst)
    ((sndEp1 || sndEp2) && st_q.idx == 4'h5 && highSpeed) |-> romData == uds_pkg::UDS_MPS_HS[15:8])
    else $error("bulk packet size high byte wrong");
  a_ep2_addr: assert property (@(posedge clk) disable iff (rst)
    (sndEp2 && st_q.idx == 4'h2) |-> romData == uds_pkg::UDS_EP2_ADDR)
    else $error("ep2 address wrong");
  a_bulk_attr: assert property (@(posedge clk) disable iff (rst)
    (sndEp2 && st_q.idx == 4'h3) |-> romData == uds_pkg::UDS_ATTR_BULK)
    else $error("ep2 attribute wrong");
  a_ep2_ival: assert property (@(posedge clk) disable iff (rst)
    (sndEp2 && st_q.idx == 4'h6) |-> romData == uds_pkg::UDS_ZERO)
    else $error("ep2 interval wrong");
  a_ep3_addr: assert property (@(posedge clk) disable iff (rst)
    (sndEp3 && st_q.idx == 4'h2) |-> romData == uds_pkg::UDS_EP3_ADDR)
    else $error("ep3 address wrong");
  a_ep3_attr: assert property (@(posedge clk) disable iff (rst)
    (sndEp3 && st_q.idx == 4'h3) |-> romData == uds_pkg::UDS_ATTR_INTR)
    else $error("ep3 attribute wrong");
  a_ep3_mps: assert property (@(posedge clk) disable iff (rst)
    (sndEp3 && st_q.idx == 4'h4) |-> romData == uds_pkg::UDS_MPS_EP3[7:0])
    else $error("ep3 packet size wrong");
  a_ep3_int: assert property (@(posedge clk) disable iff (rst)
    (sndEp3 && st_q.idx == 4'h6 && !eeValid) |-> romData == uds_pkg::UDS_DEF_EP3INT)
    else $error("ep3 interval default wrong");
  a_ep3_load: assert property (@(posedge clk) disable iff (rst)
    (sndEp3 && st_q.idx == 4'h6 && eeValid) |-> romData == ee.ep3Interval)
    else $error("ep3 loaded interval wrong");

  // ****************************************************************
  // other speed configuration descriptor
  // ****************************************************************
  a_osc_len: assert property (@(posedge clk) disable iff (rst)
    sndOsc |-> romLen == uds_pkg::UDS_LEN_OSC)
    else $error("osc length wrong");
  a_osc_type: assert property (@(posedge clk) disable iff (rst)
    (sndOsc && st_q.idx == 4'h1) |-> romData == uds_pkg::UDS_TYPE_OSC)
    else $error("osc type wrong");
  a_osc_total: assert property (@(posedge clk) disable iff (rst)
    (sndOsc && st_q.idx == 4'h2) |-> romData == uds_pkg::UDS_TOTAL_OSC[7:0])
    else $error("osc total length wrong");
  a_osc_nintf: assert property (@(posedge clk) disable iff (rst)
    (sndOsc && st_q.idx == 4'h4) |-> romData == uds_pkg::UDS_ONE)
    else $error("osc interface count wrong");
  a_osc_cfgval: assert property (@(posedge clk) disable iff (rst)
    (sndOsc && st_q.idx == 4'h5) |-> romData == uds_pkg::UDS_ONE)
    else $error("osc configuration value wrong");
  a_osc_speed: assert property (@(posedge clk) disable iff (rst)
    (sndOsc && st_q.idx == 4'h7 && eeValid)
    |-> romData == (highSpeed ? ee.fsCfgAttr : ee.hsCfgAttr))
    else $error("osc attributes from wrong speed set");
  a_attr_def: assert property (@(posedge clk) disable iff (rst)
    (sndOsc && st_q.idx == 4'h7 && !eeValid)
    |-> (romData & 8'hDF) == (uds_pkg::UDS_DEF_ATTR & 8'hDF))
    else $error("osc attributes default wrong");
  a_attr_strap: assert property (@(posedge clk) disable iff (rst)
    (sndOsc && st_q.idx == 4'h7 && !eeValid) |-> romData[uds_pkg::UDS_WAKE_BIT] == st_q.strap)
    else $error("wakeup bit does not follow strap");
  a_pwr_def: assert property (@(posedge clk) disable iff (rst)
    (sndOsc && st_q.idx == 4'h8 && !eeValid)
    |-> romData == (selfPower ? uds_pkg::UDS_PWR_SELF : uds_pkg::UDS_PWR_BUS))
    else $error("max power default wrong");
  a_str_def: assert property (@(posedge clk) disable iff (rst)
    (sndOsc && st_q.idx == 4'h6 && !eeValid) |-> romData == uds_pkg::UDS_DEF_STR)
    else $error("osc string default wrong");

  // ****************************************************************
  // stream handshake
  // ****************************************************************
  a_no_overrun: assert property (@(posedge clk) disable iff (rst)
    dout.valid |-> st_q.idx <= 4'h9)
    else $error("byte past descriptor");
  a_last_idle: assert property (@(posedge clk) disable iff (rst)
    (dout.valid && dout.last) |-> !busy)
    else $error("busy after last");
  a_req_start: assert property (@(posedge clk) disable iff (rst)
    (st_q.state == S_IDLE && reqValid && req.reqLen != 8'h00) |-> ##2 busy ##1 dout.valid)
    else $error("first byte late");
  a_stream_gap: assert property (@(posedge clk) disable iff (rst)
    dout.valid |=> !dout.valid)
    else $error("bytes closer than two cycles");
  a_zero_len: assert property (@(posedge clk) disable iff (rst)
    (st_q.state == S_IDLE && reqValid && req.reqLen == 8'h00) |=> (!dout.valid) [*4])
    else $error("byte sent for zero length");
  a_busy_ignore: assert property (@(posedge clk) disable iff (rst)
    (reqValid && busy) |=> ($stable(st_q.sel) && $stable(st_q.reqLen)))
    else $error("request taken while busy");

  c_intf: cover property (@(posedge clk) st_q.sel == uds_pkg::UDS_SEL_INTF && dout.last);
  c_osc: cover property (@(posedge clk) st_q.sel == uds_pkg::UDS_SEL_OSC && dout.last);
  c_short: cover property (@(posedge clk) dout.last && st_q.reqLen < romLen);
  c_poke: cover property (@(posedge clk) reqValid && busy);
  c_zero: cover property (@(posedge clk) st_q.state == S_IDLE && reqValid && req.reqLen == 8'h00);
endmodule // uds_store

/* File: verif/uds_host_model.sv */
// host side model: issues descriptor requests and collects the returned bytes
// assumes get is called just after a rising clock edge
`timescale 1ns/1ps
module uds_host_model (
  input  wire logic                  clk,      // core clock
  input  wire uds_pkg::uds_byte_type dout,     // byte stream from the store
  input  wire logic                  busy,     // store busy
  output uds_pkg::uds_req_type       req,      // request fields
  output logic                       reqValid  // request strobe
);
  logic [7:0] rx [16];
  int         rxCnt;
  int         lastAt;
  int         k;

  initial begin
    reqValid = 1'b0;
    req      = '1;
  end

  always @(posedge clk) begin
    if (dout.valid === 1'b1) begin
      if (dout.last === 1'b1) lastAt = rxCnt;
      if (rxCnt < 16) rx[rxCnt] = dout.data;
      rxCnt++;
    end
  end

  // poke holds the strobe one more edge with other fields, which must be ignored
  task automatic get(input uds_pkg::uds_sel_type s, input logic [7:0] n, input bit poke,
                     output bit ok);
    rxCnt  = 0;
    lastAt = -1;
    k      = 0;
    while (busy !== 1'b0 && k < 50) begin
      @(posedge clk);
      #1;
      k++;
    end
    req.sel    = s;
    req.reqLen = n;
    reqValid   = 1'b1;
    @(posedge clk);
    #1;
    if (poke) begin
      req.sel    = uds_pkg::UDS_SEL_EP3;
      req.reqLen = 8'h01;
      @(posedge clk);
      #1;
    end
    reqValid = 1'b0;
    req      = ~req; // released fields do not keep their value
    k        = 0;
    while (busy === 1'b1 && k < 600) begin
      @(posedge clk);
      #1;
      k++;
    end
    @(posedge clk);
    #1;
    ok = (k < 600) && (busy === 1'b0);
  endtask
endmodule // uds_host_model

/* File: verif/uds_store_bench.sv */
// self-checking bench for the descriptor store: random requests plus corner cases
// assumes the host model owns the request port; the bench owns speed, power, strap, eeprom
`timescale 1ns/1ps
module uds_store_bench;
  logic                    clk;
  logic                    rst;
  logic                    highSpeed;
  logic                    selfPower;
  logic                    strap;
  logic                    strapQ;
  logic                    eeValid;
  uds_pkg::uds_eeprom_type ee;
  uds_pkg::uds_req_type    req;
  logic                    reqValid;
  uds_pkg::uds_byte_type   dout;
  logic                    busy;
  int                      failures;
  int                      checksDone;
  int                      seed = 32'he62d;
  int                      cyc;

  uds_store u_uds_store (.clk(clk), .rst(rst), .reqValid(reqValid), .req(req),
    .highSpeed(highSpeed), .selfPower(selfPower), .remote_wakeup_strap(strap),
    .eeValid(eeValid), .ee(ee), .dout(dout), .busy(busy));
  uds_host_model u_uds_host_model (.clk(clk), .dout(dout), .busy(busy), .req(req),
    .reqValid(reqValid));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic give_verdict;
    if (failures == 0 && checksDone > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // byte 0 sits in the low eight bits
  function automatic logic [71:0] expDesc(int s);
    logic [7:0]  oStr, oAttr, oPwr;
    logic [15:0] mps;
    mps   = highSpeed ? 16'h0200 : 16'h0040;
    oStr  = eeValid ? (highSpeed ? ee.fsCfgStr : ee.hsCfgStr) : 8'h00;
    oAttr = eeValid ? (highSpeed ? ee.fsCfgAttr : ee.hsCfgAttr) : (strapQ ? 8'hA0 : 8'h80);
    oPwr  = eeValid ? (highSpeed ? ee.fsMaxPower : ee.hsMaxPower)
                    : (selfPower ? 8'h01 : 8'hFA);
    case (s)
      0: return eeValid ? {ee.intfStr, ee.intfProto, ee.intfSub, ee.intfClass, 40'h03_0000_0409}
                        : {32'h00FF_00FF, 40'h03_0000_0409};
      1: return {8'h00, 8'h00, mps, 24'h02_8105, 8'h07};
      2: return {8'h00, 8'h00, mps, 24'h02_0205, 8'h07};
      3: return {8'h00, eeValid ? ee.ep3Interval : 8'h04, 48'h0010_0383_0507};
      default: return {oPwr, oAttr, oStr, 48'h0101_0027_0709};
    endcase
  endfunction

  task automatic phase(input logic strapLvl);
    logic [71:0] e;
    logic [7:0]  n;
    int          s, cnt;
    bit          ok;
    rst   = 1'b1;
    strap = strapLvl;
    repeat (5) @(posedge clk);
    #1;
    rst    = 1'b0;
    strapQ = strapLvl;
    repeat (2) @(posedge clk);
    #1;
    strap = ~strapLvl; // only the level at the first edge after reset counts
    for (int it = 0; it < 60; it++) begin
      s         = (it < 5) ? it : $unsigned($random(seed)) % 5;
      n         = (it < 5) ? 8'hFF : ((it == 5) ? 8'h00 : 8'($random(seed) & 15));
      highSpeed = $random(seed);
      selfPower = $random(seed);
      eeValid   = (it < 5) ? 1'b0 : 1'($random(seed));
      ee        = uds_pkg::uds_eeprom_type'(88'({$random(seed), $random(seed), $random(seed)}));
      u_uds_host_model.get(uds_pkg::uds_sel_type'(s), n, (it % 7 == 3) && n > 1, ok);
      chk(16'(ok), 16'h0001);
      e   = expDesc(s);
      cnt = ((s == 0 || s == 4) ? 9 : 7);
      if (n < cnt) cnt = n;
      chk(16'(u_uds_host_model.rxCnt), 16'(cnt));
      chk(16'(u_uds_host_model.lastAt), (cnt > 0) ? 16'(cnt - 1) : 16'hFFFF);
      for (int i = 0; i < cnt && i < 16; i++) begin
        chk({8'h00, u_uds_host_model.rx[i]}, {8'h00, e[8*i+:8]});
      end
    end
  endtask

  initial begin
    rst       = 1'b1;
    highSpeed = 1'b1;
    selfPower = 1'b0;
    strap     = 1'b1;
    strapQ    = 1'b1;
    eeValid   = 1'b0;
    ee        = '0;
    failures  = 0;
    checksDone = 0;
    cyc       = 0;
    phase(1'b1);
    phase(1'b0);
    give_verdict();
  end
endmodule // uds_store_bench
